/* File: hdl/ascf_baud.sv */
// Baud generator giving one tick per sixteenth of a bit time.
`timescale 1ns/1ps
`include "ascf_regs.svh"
module ascf_baud (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        run_i,
  input  wire logic        wide_i,
  input  wire logic [15:0] div_i,
  output logic             tick_o
);
  ascf_pkg::ascf_baud_t st;
  ascf_pkg::ascf_baud_t next_st;

  // Tick rate is the clock divided by the divisor plus one.
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (!run_i) begin
      next_st.cnt = `ASCF_DIV_RST;
    end else if (st.cnt == `ASCF_DIV_RST) begin
      next_st.cnt = wide_i ? div_i : {8'h00, div_i[7:0]};
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = 16'(st.cnt - 16'h0001);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick_o = st.tick;
endmodule

/* File: hdl/ascf_device.sv */
// Character framing core: transmitter, receiver and baud timing.
//
// Behaviour
// - Two-level NRZ line, mark one, space zero.
// - Transmitter idles at mark.
// - Frame: one start, 8/9 data, stop.
// - Start is space, stop is mark.
// - Each bit lasts one bit time.
// - Baud generator, 8 or 16 bit divider.
// - Data sent and received LSb first.
// - Independent full-duplex paths, shared format, rate; sync mode receives only while the transmitter is idle.
// - No hardware parity; ninth bit carries it.
// - Async full duplex or sync master/slave.
// - Eight or nine data bits selectable.
// - Nine-bit address detection on receive.
// - Flag overrun and framing errors.
// - Send 13-bit-time Break character.
// - Measure incoming rate, calibrate baud generator.
// - Break on input wakes sleeping device.
// - Transmit output to pin and logic cell.
// - Sync mode switches data pin direction.
// - Two-entry receive FIFO.
// - Receive sampled at sixteen times baud.
// - One-entry holding buffer until stop sent.
`timescale 1ns/1ps
`include "ascf_regs.svh"
module ascf_device (
  input  wire logic        REF_CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic        ENABLE_I,
  input  wire logic        TX_EN_I,
  input  wire logic        RX_EN_I,
  input  wire logic        SYNC_I,
  input  wire logic        MASTER_I,
  input  wire logic        NINE_BIT_I,
  input  wire logic        ADDR_DET_I,
  input  wire logic        BRG16_I,
  input  wire logic [15:0] BRG_DIV_I,
  input  wire logic        ABD_START_I,
  input  wire logic        SLEEP_I,
  input  wire logic        TX_VALID_I,
  input  wire logic [8:0]  TX_DATA_I,
  input  wire logic        TX_BREAK_I,
  output logic             TX_READY_O,
  output logic             TX_IDLE_O,
  output logic             TX_OUT_O,
  input  wire logic        RX_POP_I,
  output logic             RX_VALID_O,
  output logic [8:0]       RX_DATA_O,
  output logic             RX_FERR_O,
  output logic             RX_OVERRUN_O,
  output logic             ABD_DONE_O,
  output logic             WAKE_O,
  ascf_if.device           lnk
);
  ascf_pkg::ascf_dev_t st;
  ascf_pkg::ascf_dev_t next_st;
  logic                tick;
  logic                sub_wrap;
  logic                bit_edge;
  logic                smp_edge;
  logic                rx_in;
  logic                push;
  logic [9:0]          entry;
  logic [8:0]          data;
  logic [1:0][9:0]     f;
  logic [1:0]          v;

  // Calibrated divisor overrides the programmed one once measured.
  ascf_baud u_baud (
    .clk_i   (REF_CLK_I),
    .rst_n_i (RST_N_I),
    .run_i   (ENABLE_I),
    .wide_i  (BRG16_I | st.abd_ok),
    .div_i   (st.abd_ok ? st.abd_div : BRG_DIV_I),
    .tick_o  (tick)
  );

  always_comb begin
    next_st = st;
    next_st.wake = 1'b0;
    rx_in = lnk.dt_line;
    next_st.rx_prev = rx_in;
    next_st.ck_prev = lnk.ck_line;
    push = 1'b0;
    entry = '0;
    data = '0;
    sub_wrap = tick & (st.tx_sub == `ASCF_SUB_LAST);
    bit_edge = (SYNC_I & !MASTER_I) ? (st.ck_prev & !lnk.ck_line)
                                    : sub_wrap;
    smp_edge = MASTER_I ? (tick & (st.tx_sub == `ASCF_SUB_MID))
                        : (!st.ck_prev & lnk.ck_line);

    // Transmit path.
    if (tick & (st.tx_busy | SYNC_I)) begin
      next_st.tx_sub = 4'(st.tx_sub + 4'h1);
    end
    if (st.tx_busy & bit_edge) begin
      next_st.tx_sh = {`ASCF_MARK, st.tx_sh[13:1]};
      next_st.tx_cnt = 4'(st.tx_cnt - 4'h1);
      next_st.tx_busy = st.tx_cnt != 4'h1;
    end else if (!st.tx_busy & st.hold_vld & TX_EN_I & ENABLE_I
                 & (!SYNC_I | bit_edge)) begin
      // Held character moves in the cycle after the last stop bit.
      next_st.hold_vld = 1'b0;
      next_st.tx_busy = 1'b1;
      if (SYNC_I) begin
        next_st.tx_sh = {5'h1F, st.hold};
        next_st.tx_cnt = NINE_BIT_I ? `ASCF_SYN9 : `ASCF_SYN8;
      end else begin
        next_st.tx_sub = 4'h0;
        if (st.hold_brk) begin
          // Start plus twelve zeros gives thirteen low bit times.
          next_st.tx_sh = {`ASCF_MARK, 13'h0000};
          next_st.tx_cnt = `ASCF_LEN_BRK;
        end else if (NINE_BIT_I) begin
          next_st.tx_sh = {4'hF, st.hold, `ASCF_SPACE};
          next_st.tx_cnt = `ASCF_LEN9;
        end else begin
          next_st.tx_sh = {5'h1F, st.hold[7:0], `ASCF_SPACE};
          next_st.tx_cnt = `ASCF_LEN8;
        end
      end
    end
    if (TX_VALID_I & !st.hold_vld) begin
      next_st.hold_vld = 1'b1;
      next_st.hold = TX_DATA_I;
      next_st.hold_brk = TX_BREAK_I;
    end

    // Receive path, independent of the transmitter in async mode; sync mode samples only while the transmitter is idle.
    if (tick & (st.rx_st != ascf_pkg::RX_IDLE) & !SYNC_I) begin
      next_st.rx_sub = 4'(st.rx_sub + 4'h1);
    end
    if (!ENABLE_I | !RX_EN_I) begin
      next_st.rx_st = ascf_pkg::RX_IDLE;
      next_st.ovr = 1'b0;
    end else if (SYNC_I) begin
      next_st.rx_st = ascf_pkg::RX_DATA;
      if (smp_edge & !st.tx_busy) begin
        next_st.rx_sh = {rx_in, st.rx_sh[8:1]};
        next_st.rx_n = 4'(st.rx_n + 4'h1);
        if (st.rx_n == (NINE_BIT_I ? `ASCF_LAST9 : `ASCF_LAST8)) begin
          next_st.rx_n = 4'h0;
          push = 1'b1;
          data = ascf_pkg::ascf_frame_data({rx_in, st.rx_sh[8:1]},
                                           NINE_BIT_I);
        end
      end
    end else begin
      unique case (st.rx_st)
        ascf_pkg::RX_IDLE: begin
          if (st.rx_prev & !rx_in & !st.abd_arm) begin
            next_st.rx_st = ascf_pkg::RX_START;
            next_st.rx_sub = 4'h0;
          end
        end
        ascf_pkg::RX_START: begin
          // A glitch shorter than half a bit is not a start.
          if (tick & (st.rx_sub == `ASCF_SUB_MID)) begin
            next_st.rx_st = rx_in ? ascf_pkg::RX_IDLE : ascf_pkg::RX_DATA;
            next_st.rx_sub = 4'h0;
            next_st.rx_n = 4'h0;
          end
        end
        ascf_pkg::RX_DATA: begin
          if (tick & (st.rx_sub == `ASCF_SUB_LAST)) begin
            next_st.rx_sh = {rx_in, st.rx_sh[8:1]};
            next_st.rx_n = 4'(st.rx_n + 4'h1);
            if (st.rx_n == (NINE_BIT_I ? `ASCF_LAST9 : `ASCF_LAST8)) begin
              next_st.rx_st = ascf_pkg::RX_STOP;
            end
          end
        end
        ascf_pkg::RX_STOP: begin
          if (tick & (st.rx_sub == `ASCF_SUB_LAST)) begin
            next_st.rx_st = ascf_pkg::RX_IDLE;
            push = 1'b1;
            data = ascf_pkg::ascf_frame_data(st.rx_sh, NINE_BIT_I);
            entry[9] = rx_in != `ASCF_MARK;
          end
        end
      endcase
    end
    entry[8:0] = data;
    // Data characters are dropped while waiting for an address.
    if (NINE_BIT_I & ADDR_DET_I & !data[8]) begin
      push = 1'b0;
    end

    // Receive FIFO: entry 0 is always the oldest character.
    f = st.fifo;
    v = st.vld;
    if (RX_POP_I & st.vld[0]) begin
      f[0] = st.fifo[1];
      v = {1'b0, st.vld[1]};
    end
    if (push) begin
      if (!v[0]) begin
        f[0] = entry;
        v[0] = 1'b1;
      end else if (!v[1]) begin
        f[1] = entry;
        v[1] = 1'b1;
      end else begin
        next_st.ovr = 1'b1;
      end
    end
    next_st.fifo = f;
    next_st.vld = v;

    // Rate measurement over the start bit of a sync character.
    if (ABD_START_I) begin
      next_st.abd_arm = 1'b1;
      next_st.abd_ok = 1'b0;
      next_st.abd_run = 1'b0;
    end else if (st.abd_arm & !st.abd_run & st.rx_prev & !rx_in) begin
      next_st.abd_run = 1'b1;
      next_st.abd_cnt = 20'h0_0000;
    end else if (st.abd_run & !rx_in) begin
      next_st.abd_cnt = 20'(st.abd_cnt + 20'h0_0001);
    end else if (st.abd_run) begin
      next_st.abd_run = 1'b0;
      next_st.abd_arm = 1'b0;
      next_st.abd_ok = 1'b1;
      next_st.abd_div = (st.abd_cnt[19:4] == 16'h0000) ? 16'h0000
                        : 16'(st.abd_cnt[19:4] - 16'h0001);
    end

    // A falling input while asleep is the leading edge of a break.
    next_st.wake = SLEEP_I & st.rx_prev & !rx_in;

    // Pins and status.
    next_st.tx_rdy = !next_st.hold_vld;
    next_st.tx_idle = !next_st.tx_busy;
    next_st.tx_out = next_st.tx_busy ? next_st.tx_sh[0] : `ASCF_MARK;
    if (SYNC_I) begin
      next_st.ck_oe = MASTER_I;
      next_st.ck_o = (next_st.tx_busy | RX_EN_I) & next_st.tx_sub[3];
      next_st.dt_oe = next_st.tx_busy;
      next_st.dt_o = next_st.tx_out;
    end else begin
      next_st.ck_oe = ENABLE_I;
      next_st.ck_o = next_st.tx_out;
      next_st.dt_oe = 1'b0;
      next_st.dt_o = `ASCF_MARK;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st <= '0;
      st.rx_prev <= `ASCF_MARK;
      st.tx_rdy <= 1'b1;
      st.tx_idle <= 1'b1;
      st.tx_out <= `ASCF_MARK;
      st.ck_o <= `ASCF_MARK;
      st.dt_o <= `ASCF_MARK;
    end else begin
      st <= next_st;
    end
  end

  assign TX_READY_O = st.tx_rdy;
  assign TX_IDLE_O = st.tx_idle;
  assign TX_OUT_O = st.tx_out;
  assign RX_VALID_O = st.vld[0];
  assign RX_DATA_O = st.fifo[0][8:0];
  assign RX_FERR_O = st.fifo[0][9];
  assign RX_OVERRUN_O = st.ovr;
  assign ABD_DONE_O = st.abd_ok;
  assign WAKE_O = st.wake;
  assign lnk.dev_ck_o = st.ck_o;
  assign lnk.dev_ck_oe = st.ck_oe;
  assign lnk.dev_dt_o = st.dt_o;
  assign lnk.dev_dt_oe = st.dt_oe;
endmodule

/* File: hdl/ascf_if.sv */
// Link between the framing core and the remote serial node.
`timescale 1ns/1ps
interface ascf_if;
  logic dev_ck_o;
  logic dev_ck_oe;
  logic dev_dt_o;
  logic dev_dt_oe;
  logic rem_ck_o;
  logic rem_ck_oe;
  logic rem_dt_o;
  logic rem_dt_oe;
  logic ck_line;
  logic dt_line;

  // An undriven pin floats to the mark level through its pull-up.
  assign ck_line = dev_ck_oe ? dev_ck_o : (rem_ck_oe ? rem_ck_o : 1'b1);
  assign dt_line = dev_dt_oe ? dev_dt_o : (rem_dt_oe ? rem_dt_o : 1'b1);

  modport device (output dev_ck_o, dev_ck_oe, dev_dt_o, dev_dt_oe,
                  input  ck_line, dt_line);
  modport remote (output rem_ck_o, rem_ck_oe, rem_dt_o, rem_dt_oe,
                  input  ck_line, dt_line);
endinterface

/* File: hdl/ascf_pkg.sv */
// Types and shared decode of the serial framing core.
package ascf_pkg;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ascf_rx_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } ascf_baud_t;

  typedef struct packed {
    logic            hold_vld;
    logic [8:0]      hold;
    logic            hold_brk;
    logic            tx_busy;
    logic [13:0]     tx_sh;
    logic [3:0]      tx_cnt;
    logic [3:0]      tx_sub;
    ascf_rx_t        rx_st;
    logic [3:0]      rx_sub;
    logic [3:0]      rx_n;
    logic [8:0]      rx_sh;
    logic            rx_prev;
    logic            ck_prev;
    logic [1:0][9:0] fifo;
    logic [1:0]      vld;
    logic            ovr;
    logic            abd_arm;
    logic            abd_run;
    logic [19:0]     abd_cnt;
    logic [15:0]     abd_div;
    logic            abd_ok;
    logic            wake;
    logic            tx_rdy;
    logic            tx_idle;
    logic            tx_out;
    logic            ck_o;
    logic            ck_oe;
    logic            dt_o;
    logic            dt_oe;
  } ascf_dev_t;

  typedef struct packed {
    logic        tx_busy;
    logic [11:0] tx_sh;
    logic [3:0]  tx_cnt;
    logic [3:0]  tx_sub;
    logic        line;
    ascf_rx_t    rx_st;
    logic [3:0]  rx_sub;
    logic [3:0]  rx_n;
    logic [8:0]  rx_sh;
    logic        rx_prev;
    logic        rx_vld;
    logic [8:0]  rx_dat;
    logic        rx_ferr;
    logic        tx_rdy;
  } ascf_rem_t;

  // Bits arrive LSb first into the top of the shifter, so an 8-bit
  // character ends up one place high.
  function automatic logic [8:0] ascf_frame_data(input logic [8:0] sh,
                                                 input logic       nine);
    ascf_frame_data = nine ? sh : {1'b0, sh[8:1]};
  endfunction

endpackage

/* File: hdl/ascf_regs.svh */
// Bit timing and frame layout constants of the serial framing core.
`ifndef ASCF_REGS_SVH
`define ASCF_REGS_SVH

`define ASCF_SUB_MID  4'h7
`define ASCF_SUB_LAST 4'hF
`define ASCF_LEN8     4'hA
`define ASCF_LEN9     4'hB
`define ASCF_LEN_BRK  4'hE
`define ASCF_SYN8     4'h8
`define ASCF_SYN9     4'h9
`define ASCF_LAST8    4'h7
`define ASCF_LAST9    4'h8
`define ASCF_MARK     1'b1
`define ASCF_SPACE    1'b0
`define ASCF_DIV_RST  16'h0000

`endif

/* File: hdl/ascf_remote.sv */
// Remote asynchronous serial node at the far end of the link.
`timescale 1ns/1ps
`include "ascf_regs.svh"
module ascf_remote (
  input  wire logic        REF_CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic [15:0] DIV_I,
  input  wire logic        NINE_BIT_I,
  input  wire logic        STOP2_I,
  input  wire logic        TX_VALID_I,
  input  wire logic [8:0]  TX_DATA_I,
  output logic             TX_READY_O,
  output logic             RX_VALID_O,
  output logic [8:0]       RX_DATA_O,
  output logic             RX_FERR_O,
  ascf_if.remote           lnk
);
  ascf_pkg::ascf_rem_t st;
  ascf_pkg::ascf_rem_t next_st;
  logic                tick;
  logic                sub_wrap;

  ascf_baud u_baud (
    .clk_i   (REF_CLK_I),
    .rst_n_i (RST_N_I),
    .run_i   (1'b1),
    .wide_i  (1'b1),
    .div_i   (DIV_I),
    .tick_o  (tick)
  );

  always_comb begin
    next_st = st;
    next_st.rx_vld = 1'b0;
    next_st.rx_prev = lnk.ck_line;
    sub_wrap = tick & (st.tx_sub == `ASCF_SUB_LAST);
    if (tick & st.tx_busy) begin
      next_st.tx_sub = 4'(st.tx_sub + 4'h1);
    end
    if (st.tx_busy & sub_wrap) begin
      next_st.tx_sh = {`ASCF_MARK, st.tx_sh[11:1]};
      next_st.tx_cnt = 4'(st.tx_cnt - 4'h1);
      next_st.tx_busy = st.tx_cnt != 4'h1;
    end else if (!st.tx_busy & TX_VALID_I) begin
      next_st.tx_busy = 1'b1;
      next_st.tx_sub = 4'h0;
      // Frame is start, data LSb first, one or two stop bits.
      next_st.tx_sh = NINE_BIT_I
        ? {2'b11, TX_DATA_I, `ASCF_SPACE}
        : {3'b111, TX_DATA_I[7:0], `ASCF_SPACE};
      next_st.tx_cnt = 4'((NINE_BIT_I ? `ASCF_LEN9 : `ASCF_LEN8)
                          + {3'b000, STOP2_I});
    end
    // Idle and stop bits sit at mark.
    next_st.line = next_st.tx_busy ? next_st.tx_sh[0] : `ASCF_MARK;
    next_st.tx_rdy = !next_st.tx_busy;

    if (tick & (st.rx_st != ascf_pkg::RX_IDLE)) begin
      next_st.rx_sub = 4'(st.rx_sub + 4'h1);
    end
    unique case (st.rx_st)
      ascf_pkg::RX_IDLE: begin
        if (st.rx_prev & !lnk.ck_line) begin
          next_st.rx_st = ascf_pkg::RX_START;
          next_st.rx_sub = 4'h0;
        end
      end
      ascf_pkg::RX_START: begin
        if (tick & (st.rx_sub == `ASCF_SUB_MID)) begin
          next_st.rx_st = lnk.ck_line ? ascf_pkg::RX_IDLE
                                      : ascf_pkg::RX_DATA;
          next_st.rx_sub = 4'h0;
          next_st.rx_n = 4'h0;
        end
      end
      ascf_pkg::RX_DATA: begin
        if (tick & (st.rx_sub == `ASCF_SUB_LAST)) begin
          next_st.rx_sh = {lnk.ck_line, st.rx_sh[8:1]};
          next_st.rx_n = 4'(st.rx_n + 4'h1);
          if (st.rx_n == (NINE_BIT_I ? `ASCF_LAST9 : `ASCF_LAST8)) begin
            next_st.rx_st = ascf_pkg::RX_STOP;
          end
        end
      end
      ascf_pkg::RX_STOP: begin
        if (tick & (st.rx_sub == `ASCF_SUB_LAST)) begin
          next_st.rx_st = ascf_pkg::RX_IDLE;
          next_st.rx_vld = 1'b1;
          next_st.rx_dat = ascf_pkg::ascf_frame_data(st.rx_sh, NINE_BIT_I);
          next_st.rx_ferr = !lnk.ck_line;
        end
      end
    endcase
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st <= '0;
      st.line <= `ASCF_MARK;
      st.rx_prev <= `ASCF_MARK;
      st.tx_rdy <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign TX_READY_O = st.tx_rdy;
  assign RX_VALID_O = st.rx_vld;
  assign RX_DATA_O = st.rx_dat;
  assign RX_FERR_O = st.rx_ferr;
  assign lnk.rem_dt_o = st.line;
  assign lnk.rem_dt_oe = 1'b1;
  assign lnk.rem_ck_o = `ASCF_MARK;
  assign lnk.rem_ck_oe = 1'b0;
endmodule

/* File: test/ascf_link_monitor.sv */
// Line checks on the link between the framing core and the remote node.
`timescale 1ns/1ps
module ascf_link_monitor #(
  parameter int BIT_CLKS = 16
) (
  input  wire logic REF_CLK_I,
  input  wire logic RST_N_I,
  input  wire logic ck_line,
  input  wire logic dt_line
);
  localparam int BRK_CLKS = 13 * BIT_CLKS;
  localparam int CHR_CLKS = 10 * BIT_CLKS;

  typedef struct packed {
    logic [15:0] ck_low;
    logic [15:0] dt_low;
  } ascf_mon_t;

  ascf_mon_t cur;
  ascf_mon_t next_cur;

  // Length of the present space run on each line, in clocks.
  always_comb begin
    next_cur = cur;
    next_cur.ck_low = ck_line ? 16'h0000 : cur.ck_low + 16'h0001;
    next_cur.dt_low = dt_line ? 16'h0000 : cur.dt_low + 16'h0001;
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  default clocking mon_clk @(posedge REF_CLK_I);
  endclocking
  default disable iff (!RST_N_I);

  // The repetitions below assume sixteen clocks to a bit.
  a_ck_bit_whole: assert property ($rose(ck_line) |->
    (cur.ck_low % BIT_CLKS) == 0) else $error("ck space run not whole bits");
  a_ck_low_bound: assert property (cur.ck_low <= BRK_CLKS)
    else $error("ck space run longer than a break");
  a_ck_start_bit: assert property ($fell(ck_line) |->
    !ck_line[*8] ##1 !ck_line[*8]) else $error("ck space shorter than a bit");
  a_ck_mark_bit: assert property ($rose(ck_line) |->
    ck_line[*8] ##1 ck_line[*8]) else $error("ck mark shorter than a bit");
  a_dt_bit_whole: assert property ($rose(dt_line) |->
    (cur.dt_low % BIT_CLKS) == 0) else $error("dt space run not whole bits");
  a_dt_low_bound: assert property (cur.dt_low <= CHR_CLKS)
    else $error("dt space run longer than a character");
  a_dt_start_bit: assert property ($fell(dt_line) |->
    !dt_line[*8] ##1 !dt_line[*8]) else $error("dt space shorter than a bit");
  a_dt_mark_bit: assert property ($rose(dt_line) |->
    dt_line[*8] ##1 dt_line[*8]) else $error("dt mark shorter than a bit");
endmodule

/* File: test/testbench.sv */
// Self-checking bench joining the framing core to the remote node.
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic       nine;
    logic       wide;
    logic       stop2;
    logic [8:0] dat;
  } ascf_row_t;
  localparam int NROWS = 6;
  localparam int LIMIT = 30000;
  localparam ascf_row_t ROWS [NROWS] = '{
    '{1'b0, 1'b1, 1'b0, 9'h055}, '{1'b0, 1'b0, 1'b1, 9'h0A3},
    '{1'b0, 1'b1, 1'b1, 9'h1FF}, '{1'b1, 1'b1, 1'b0, 9'h100},
    '{1'b1, 1'b0, 1'b0, 9'h0FE}, '{1'b1, 1'b1, 1'b1, 9'h001}};

  logic        clk, rst_n, nine, wide, stop2, tx_en, rx_en, sleep, addr_det;
  logic        dev_vld, dev_brk, rem_vld, pop, rem_fe;
  logic [15:0] div;
  logic [8:0]  dev_dat, rem_dat, rem_last, exp_dat;
  logic        dev_rdy, dev_idle, dev_out, d_vld, d_ferr, d_ovr, wake;
  logic        rem_rdy, r_vld, r_ferr, abd_start, abd_done;
  logic [8:0]  d_dat, r_dat;
  int          fails, compares, cycles, rem_cnt, wake_cnt, base, n;

  ascf_if ascf_if_inst ();
  ascf_link_monitor #(.BIT_CLKS(16)) ascf_link_monitor_inst (
    .REF_CLK_I(clk), .RST_N_I(rst_n),
    .ck_line(ascf_if_inst.ck_line), .dt_line(ascf_if_inst.dt_line));
  ascf_device ascf_device_inst (
    .REF_CLK_I(clk), .RST_N_I(rst_n), .ENABLE_I(1'b1), .TX_EN_I(tx_en),
    .RX_EN_I(rx_en), .SYNC_I(1'b0), .MASTER_I(1'b0), .NINE_BIT_I(nine),
    .ADDR_DET_I(addr_det), .BRG16_I(wide), .BRG_DIV_I(div),
    .ABD_START_I(abd_start), .SLEEP_I(sleep), .TX_VALID_I(dev_vld),
    .TX_DATA_I(dev_dat), .TX_BREAK_I(dev_brk), .TX_READY_O(dev_rdy),
    .TX_IDLE_O(dev_idle), .TX_OUT_O(dev_out), .RX_POP_I(pop),
    .RX_VALID_O(d_vld), .RX_DATA_O(d_dat), .RX_FERR_O(d_ferr),
    .RX_OVERRUN_O(d_ovr), .ABD_DONE_O(abd_done), .WAKE_O(wake),
    .lnk(ascf_if_inst.device));
  ascf_remote ascf_remote_inst (
    .REF_CLK_I(clk), .RST_N_I(rst_n), .DIV_I(16'h0000), .NINE_BIT_I(nine),
    .STOP2_I(stop2), .TX_VALID_I(rem_vld), .TX_DATA_I(rem_dat),
    .TX_READY_O(rem_rdy), .RX_VALID_O(r_vld), .RX_DATA_O(r_dat),
    .RX_FERR_O(r_ferr), .lnk(ascf_if_inst.remote));

  initial clk = 1'b0;
  always #10 clk = ~clk;

  task automatic report_and_stop();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // The remote flags a character for one cycle only, so count them here.
  always @(posedge clk) begin
    cycles++;
    if (r_vld === 1'b1) begin
      rem_cnt++;
      rem_last = r_dat;
      rem_fe = r_ferr;
    end
    if (wake === 1'b1) wake_cnt++;
    if (cycles == LIMIT) begin
      fails++;
      report_and_stop();
    end
  end

  task automatic check(input string what, input logic [8:0] seen,
                       input logic [8:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // A late edge first keeps the strobe from being set twice in one step.
  task automatic dev_send(input logic [8:0] d, input logic brk);
    @(posedge clk);
    dev_dat <= d;
    dev_brk <= brk;
    dev_vld <= 1'b1;
    do @(posedge clk); while (dev_rdy !== 1'b1);
    dev_vld <= 1'b0;
    dev_brk <= 1'b0;
  endtask

  task automatic rem_send(input logic [8:0] d);
    @(posedge clk);
    rem_dat <= d;
    rem_vld <= 1'b1;
    do @(posedge clk); while (rem_rdy !== 1'b1);
    rem_vld <= 1'b0;
  endtask

  task automatic pop_head();
    while (d_vld !== 1'b1) @(posedge clk);
    pop <= 1'b1;
    @(posedge clk);
    pop <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  initial begin
    {rst_n, nine, stop2, sleep, addr_det, dev_vld, dev_brk, rem_vld} = '0;
    {pop, abd_start, fails, compares, cycles, rem_cnt, wake_cnt} = '0;
    {wide, tx_en, rx_en} = 3'b111;
    div = 16'h0000;
    dev_dat = 9'h000;
    rem_dat = 9'h000;
    repeat (8) @(posedge clk);
    check("idle out", dev_out, 9'h001);
    rst_n <= 1'b1;
    for (int i = 0; i < NROWS; i++) begin
      nine <= ROWS[i].nine;
      wide <= ROWS[i].wide;
      stop2 <= ROWS[i].stop2;
      div <= ROWS[i].wide ? 16'h0000 : 16'h0100;
      exp_dat = ROWS[i].nine ? ROWS[i].dat : {1'b0, ROWS[i].dat[7:0]};
      base = rem_cnt;
      fork
        dev_send(ROWS[i].dat, 1'b0);
        rem_send(ROWS[i].dat);
      join
      while (rem_cnt == base) @(posedge clk);
      check("remote rx", rem_last, exp_dat);
      check("remote ferr", {8'h00, rem_fe}, 9'h000);
      while (d_vld !== 1'b1) @(posedge clk);
      check("device rx", d_dat, exp_dat);
      check("device ferr", {8'h00, d_ferr}, 9'h000);
      pop_head();
      repeat (48) @(posedge clk);
      $display("row %0d done", i);
    end
    // A held character waits for the enable, then one queues behind it.
    {nine, stop2, div} <= '0;
    wide <= 1'b1;
    tx_en <= 1'b0;
    base = rem_cnt;
    dev_send(9'h0A5, 1'b0);
    repeat (40) @(posedge clk);
    check("held idle", {8'h00, dev_idle}, 9'h001);
    tx_en <= 1'b1;
    dev_send(9'h03C, 1'b0);
    repeat (2) @(posedge clk);
    check("queued rdy", {8'h00, dev_rdy}, 9'h000);
    while (rem_cnt < base + 1) @(posedge clk);
    check("first", rem_last, 9'h0A5);
    while (rem_cnt < base + 2) @(posedge clk);
    check("second", rem_last, 9'h03C);
    $display("back to back done");
    rem_send(9'h011);
    rem_send(9'h022);
    rem_send(9'h033);
    while (d_ovr !== 1'b1) @(posedge clk);
    check("head one", d_dat, 9'h011);
    pop_head();
    check("head two", d_dat, 9'h022);
    pop_head();
    check("drained", {8'h00, d_vld}, 9'h000);
    rx_en <= 1'b0;
    repeat (2) @(posedge clk);
    check("ovr clear", {8'h00, d_ovr}, 9'h000);
    rx_en <= 1'b1;
    $display("overrun done");
    nine <= 1'b1;
    addr_det <= 1'b1;
    sleep <= 1'b1;
    base = wake_cnt;
    rem_send(9'h055);
    repeat (20) @(posedge clk);
    sleep <= 1'b0;
    rem_send(9'h1AA);
    while (d_vld !== 1'b1) @(posedge clk);
    check("address", d_dat, 9'h1AA);
    check("wake", 9'(wake_cnt > base), 9'h001);
    pop_head();
    {nine, addr_det} <= 2'b00;
    $display("address and wake done");
    dev_send(9'h000, 1'b1);
    while (ascf_if_inst.ck_line !== 1'b0) @(posedge clk);
    n = 0;
    while (ascf_if_inst.ck_line === 1'b0) begin
      @(posedge clk);
      n++;
    end
    check("break len", 9'(n), 9'(13 * 16));
    $display("break done");
    // The first low period of the next character sets the calibrated rate.
    abd_start <= 1'b1;
    @(posedge clk);
    abd_start <= 1'b0;
    rem_send(9'h055);
    repeat (200) @(posedge clk);
    check("abd done", {8'h00, abd_done}, 9'h001);
    $display("auto baud done");
    repeat (100) @(posedge clk);
    dev_send(9'h000, 1'b0);
    repeat (30) @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    check("rst out", {dev_out, dev_idle, dev_rdy}, 9'h007);
    check("rst rx", {d_vld, d_ovr, ascf_if_inst.ck_line}, 9'h001);
    check("rst abd", {8'h00, abd_done}, 9'h000);
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (50) @(posedge clk);
    $display("reset done");
    report_and_stop();
  end
endmodule
